// [pkg/core_regs.svh]
// field positions, opcodes, addresses and reset values of the core
`ifndef CORE_REGS_SVH
`define CORE_REGS_SVH
// four clocks per instruction cycle: fetch, latch, spare, execute
`define PH_FETCH   2'h0
`define PH_LATCH   2'h1
`define PH_LAST    2'h3
`define PH_STEP    2'h1
`define RESET_VEC  10'h000
`define TBL_PAGE   2'h3
`define PC_STEP    10'h001
// data memory
`define ADDR_PCL   8'h02
`define DM_AW      5
`define DM_WORDS   32
`define DM_RST     8'h00
// instruction fields
`define F_OP       15:12
`define F_FN       11:8
`define F_BIT      10:8
`define F_ARG      7:0
`define F_TGT      9:0
// opcode classes
`define OP_MISC    4'h0
`define OP_JMP     4'h1
`define OP_CALL    4'h2
`define OP_ALU_A   4'h3
`define OP_ALU_M   4'h4
`define OP_ALU_X   4'h5
`define OP_LD_A    4'h6
`define OP_ST_M    4'h7
`define OP_LD_X    4'h8
`define OP_BSET    4'h9
`define OP_BCLR    4'hA
`define OP_SKB0    4'hB
`define OP_SKB1    4'hC
`define OP_SKZ     4'hD
`define MI_RET     4'h1
`define MI_INTERRUPT_EXIT    4'h2
`define MI_TBL     4'h3
// register port
`define RA_CTRL    4'h0
`define RA_ACC     4'h1
`define RA_PC      4'h2
`define RA_FLAG    4'h3
`define RA_TBLH    4'h4
`define CTRL_RUN   0
`define CTRL_RST   1'b1
`endif

// [pkg/core_pkg.sv]
// types shared by the core files
package core_pkg;
   typedef enum logic [3:0] {
      FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_AND, FN_OR, FN_XOR, FN_CPL,
      FN_INC, FN_DEC, FN_RR, FN_RL, FN_RRC, FN_RLC, FN_PASS, FN_NONE
   } alu_fn_t;
   // gray path boot -> run -> table -> run
   typedef enum logic [1:0] {
      ST_BOOT  = 2'b00,
      ST_RUN   = 2'b01,
      ST_TABLE = 2'b11
   } state_t;
   typedef struct packed {
      logic z;
      logic c;
      logic ac;
      logic ov;
   } flags_t;
   typedef struct packed {
      logic [7:0] res;
      flags_t     f;
      flags_t     upd;
   } alu_out_t;
   typedef struct packed {
      logic       rd;
      logic [9:0] addr;
   } pm_req_t;
endpackage

// [rtl/core_alu.sv]
// 8-bit arithmetic, logic and rotate unit
`timescale 1ns/10ps
`default_nettype none
module core_alu
(
   input  wire core_pkg::alu_fn_t fn,
   input  wire logic [7:0]        a,
   input  wire logic [7:0]        b,
   input  wire logic              cin,
   output core_pkg::alu_out_t     o
);
   import core_pkg::*;
   logic [8:0] sum;   // full add or subtract
   logic [4:0] half;  // low nibble for half carry
   logic       ci;    // carry or borrow in
   logic       sub;   // subtract family

   // one result and flag set per function
   always_comb
   begin
      o = '0;
      sub = (fn == FN_SUB) || (fn == FN_SBC);
      ci = ((fn == FN_ADC) || (fn == FN_SBC)) ? cin : 1'b0;
      if (sub)
      begin
         sum = {1'b0, a} - {1'b0, b} - {8'h00, ci};
         half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      end
      else
      begin
         sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      end
      case (fn)
         FN_ADD, FN_ADC, FN_SUB, FN_SBC:
         begin
            o.res = sum[7:0];
            o.f.c = sum[8];
            o.f.ac = half[4];
            o.f.ov = sub ? (a[7] != b[7]) && (sum[7] != a[7])
                         : (a[7] == b[7]) && (sum[7] != a[7]);
            o.upd = '{1'b1, 1'b1, 1'b1, 1'b1};
         end
         FN_AND:  begin o.res = a & b; o.upd.z = 1'b1; end
         FN_OR:   begin o.res = a | b; o.upd.z = 1'b1; end
         FN_XOR:  begin o.res = a ^ b; o.upd.z = 1'b1; end
         FN_CPL:  begin o.res = ~b; o.upd.z = 1'b1; end
         FN_INC:  begin o.res = b + 8'h01; o.upd.z = 1'b1; end
         FN_DEC:  begin o.res = b - 8'h01; o.upd.z = 1'b1; end
         FN_RR:   o.res = {b[0], b[7:1]};
         FN_RL:   o.res = {b[6:0], b[7]};
         FN_RRC:  begin o.res = {cin, b[7:1]}; o.f.c = b[0]; o.upd.c = 1'b1; end
         FN_RLC:  begin o.res = {b[6:0], cin}; o.f.c = b[7]; o.upd.c = 1'b1; end
         FN_PASS: o.res = b;
         default: o.res = a;
      endcase
      o.f.z = (o.res == 8'h00);
   end
endmodule
`default_nettype wire

// [rtl/core_dmem.sv]
// flip-flop data memory, combinational read
`timescale 1ns/10ps
`default_nettype none
`include "core_regs.svh"
module core_dmem
(
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic                we,
   input  wire logic [`DM_AW-1:0]   idx,
   input  wire logic [7:0]          wdata,
   output logic      [7:0]          rdata
);
   logic [7:0] mem [`DM_WORDS];  // storage words

   // write port, cleared by reset
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int i = 0; i < `DM_WORDS; i++)
            mem[i] <= `DM_RST;
      end
      else if (we)
         mem[idx] <= wdata;
   end

   assign rdata = mem[idx];
endmodule
`default_nettype wire

// [rtl/core_seq.sv]
// instruction sequencer and execute stage of the 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "core_regs.svh"
module core_seq
(
   input  wire logic            clk_sys,
   input  wire logic            reset,
   input  wire logic [3:0]      bus_addr,
   input  wire logic [7:0]      bus_wdata,
   input  wire logic            bus_we,
   input  wire logic            bus_re,
   output logic      [7:0]      bus_rdata,
   output core_pkg::pm_req_t    pm_req,
   input  wire logic [15:0]     pm_data
);
   import core_pkg::*;

   logic [1:0]  ph;         // clock phase in instruction cycle
   logic        run;        // software run enable
   state_t      state;      // sequencer state
   logic [9:0]  pc;         // next fetch address
   logic [15:0] ir;         // instruction being executed
   logic        ir_valid;   // ir holds a live instruction
   logic [15:0] pf;         // prefetched word
   logic [7:0]  acc;        // accumulator
   logic [7:0]  tblh;       // table read high byte
   flags_t      flags;      // z, c, ac, ov
   logic [9:0]  stk [4];    // return stack
   logic [1:0]  sp;         // stack pointer

   logic [3:0]  op;         // opcode class
   alu_fn_t     fn;         // alu function field
   logic [7:0]  arg;        // memory address or immediate
   logic [2:0]  bitidx;     // bit index field
   logic [9:0]  tgt;        // branch target
   logic [7:0]  dm_rdata;   // raw memory read
   logic [7:0]  mem_rd;     // memory read with pc low mapped
   logic [7:0]  opb;        // second alu operand
   logic [7:0]  mask;       // one-hot bit mask
   alu_out_t    alu_o;      // alu answer
   logic        commit;     // execute point of this cycle
   logic        alu_op;     // instruction uses the alu
   logic        is_jmp;     // branch or call
   logic        is_call;    // call
   logic        is_ret;     // return or interrupt return
   logic        is_tbl;     // table read
   logic        skip_op;    // conditional skip
   logic        skip_hit;   // skip test passed
   logic        mem_we;     // data write this cycle
   logic [7:0]  mem_wdata;  // data to write
   logic        pcl_sel;    // address is the pc low byte
   logic        pcl_wr;     // pc low byte written
   logic        xfer;       // flow change this cycle
   logic [9:0]  ret_addr;   // top of return stack
   logic        chk_cout;   // add carry, for checks only

   // one-hot mask for a bit index
   function automatic logic [7:0] bit_mask(input logic [2:0] i);
      bit_mask = 8'h01 << i;
   endfunction

   // field decode
   always_comb
   begin
      op = ir[`F_OP];
      fn = alu_fn_t'(ir[`F_FN]);
      arg = ir[`F_ARG];
      bitidx = ir[`F_BIT];
      tgt = ir[`F_TGT];
      mask = bit_mask(bitidx);
      pcl_sel = (arg == `ADDR_PCL);
      mem_rd = pcl_sel ? pc[7:0] : dm_rdata;
      // two-operand data always meets the accumulator
      opb = (op == `OP_ALU_X) ? arg : mem_rd;
      ret_addr = stk[sp - 2'h1];
   end

   // instruction class decode
   always_comb
   begin
      commit = run && (ph == `PH_LAST) && (state == ST_RUN) && ir_valid;
      alu_op = (op == `OP_ALU_A) || (op == `OP_ALU_M) || (op == `OP_ALU_X);
      is_call = (op == `OP_CALL);
      is_jmp = (op == `OP_JMP) || is_call;
      is_ret = (op == `OP_MISC) && ((ir[`F_FN] == `MI_RET) || (ir[`F_FN] == `MI_INTERRUPT_EXIT));
      is_tbl = (op == `OP_MISC) && (ir[`F_FN] == `MI_TBL);
      skip_op = (op == `OP_SKB0) || (op == `OP_SKB1) || (op == `OP_SKZ);
      case (op)
         `OP_SKB0: skip_hit = !mem_rd[bitidx];
         `OP_SKB1: skip_hit = mem_rd[bitidx];
         `OP_SKZ:  skip_hit = (mem_rd == 8'h00);
         default:  skip_hit = 1'b0;
      endcase
   end

   // data memory write path
   always_comb
   begin
      mem_we = commit;
      case (op)
         `OP_ALU_M: mem_wdata = alu_o.res;
         `OP_ST_M:  mem_wdata = acc;
         `OP_BSET:  mem_wdata = mem_rd | mask;
         `OP_BCLR:  mem_wdata = mem_rd & ~mask;
         default:
         begin
            mem_wdata = mem_rd;
            mem_we = 1'b0;
         end
      endcase
      pcl_wr = mem_we && pcl_sel;
      xfer = commit && (is_jmp || is_ret || pcl_wr);
      chk_cout = ({1'b0, acc} + {1'b0, opb}) > 9'h0FF;
   end

   core_alu u_alu
   (
      .fn  (fn),
      .a   (acc),
      .b   (opb),
      .cin (flags.c),
      .o   (alu_o)
   );

   // pc low byte lives in the sequencer, not in memory
   core_dmem u_dmem
   (
      .clk_sys (clk_sys),
      .reset   (reset),
      .we      (mem_we && !pcl_sel),
      .idx     (arg[`DM_AW-1:0]),
      .wdata   (mem_wdata),
      .rdata   (dm_rdata)
   );

   // phase counter, four clocks per instruction cycle
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ph <= `PH_FETCH;
      else if (run)
         ph <= ph + `PH_STEP;
   end

   // control register written from the port
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         run <= `CTRL_RST;
      else if (bus_we && (bus_addr == `RA_CTRL))
         run <= bus_wdata[`CTRL_RUN];
   end

   // sequencer state
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         state <= ST_BOOT;
      else if (run && (ph == `PH_LAST))
      begin
         case (state)
            ST_BOOT:  state <= ST_RUN;
            ST_RUN:   state <= (commit && is_tbl) ? ST_TABLE : ST_RUN;
            ST_TABLE: state <= ST_RUN;
            default:  state <= ST_BOOT;
         endcase
      end
   end

   // program counter and instruction register
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pc <= `RESET_VEC;
         ir <= '0;
         ir_valid <= 1'b0;
      end
      else if (run && (ph == `PH_LAST) && (state == ST_RUN))
      begin
         if (!ir_valid)
         begin
            // refill after a flush
            ir <= pf;
            ir_valid <= 1'b1;
            pc <= pc + `PC_STEP;
         end
         else if (is_jmp)
         begin
            pc <= tgt;
            ir_valid <= 1'b0;
         end
         else if (is_ret)
         begin
            pc <= ret_addr;
            ir_valid <= 1'b0;
         end
         else if (pcl_wr)
         begin
            pc <= {pc[9:8], mem_wdata};
            ir_valid <= 1'b0;
         end
         else if (skip_hit)
         begin
            // prefetched word is the skipped one
            pc <= pc + `PC_STEP;
            ir_valid <= 1'b0;
         end
         else
         begin
            ir <= pf;
            pc <= pc + `PC_STEP;
         end
      end
   end

   // program memory fetch and prefetch latch
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         pm_req <= '0;
         pf <= '0;
      end
      else
      begin
         pm_req.rd <= run && (ph == `PH_FETCH) && (state != ST_BOOT);
         // table cycle borrows the fetch slot
         pm_req.addr <= (state == ST_TABLE) ? {`TBL_PAGE, acc} : pc;
         if (pm_req.rd && (state == ST_RUN))
            pf <= pm_data;
      end
   end

   // accumulator and table high byte
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         acc <= 8'h00;
         tblh <= 8'h00;
      end
      else if (pm_req.rd && (state == ST_TABLE))
      begin
         acc <= pm_data[7:0];
         tblh <= pm_data[15:8];
      end
      else if (commit)
      begin
         case (op)
            `OP_ALU_A, `OP_ALU_X: acc <= alu_o.res;
            `OP_LD_A:             acc <= mem_rd;
            `OP_LD_X:             acc <= arg;
            default:              acc <= acc;
         endcase
      end
   end

   // status flags, only those the function touches
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         flags <= '0;
      else if (commit && alu_op)
      begin
         if (alu_o.upd.z)
            flags.z <= alu_o.f.z;
         if (alu_o.upd.c)
            flags.c <= alu_o.f.c;
         if (alu_o.upd.ac)
            flags.ac <= alu_o.f.ac;
         if (alu_o.upd.ov)
            flags.ov <= alu_o.f.ov;
      end
   end

   // return stack, wraps when over-filled
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         sp <= 2'h0;
         for (int i = 0; i < 4; i++)
            stk[i] <= `RESET_VEC;
      end
      else if (commit && is_call)
      begin
         stk[sp] <= pc;
         sp <= sp + 2'h1;
      end
      else if (commit && is_ret)
         sp <= sp - 2'h1;
   end

   // register read, data one cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         bus_rdata <= 8'h00;
      else if (bus_re)
      begin
         case (bus_addr)
            `RA_CTRL: bus_rdata <= {7'h00, run};
            `RA_ACC:  bus_rdata <= acc;
            `RA_PC:   bus_rdata <= pc[7:0];
            `RA_FLAG: bus_rdata <= {4'h0, flags};
            `RA_TBLH: bus_rdata <= tblh;
            default:  bus_rdata <= 8'h00;
         endcase
      end
      else
         bus_rdata <= 8'h00;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_plain;
      commit && !xfer && !skip_hit && !is_tbl;
   endsequence
   sequence s_flush;
      commit && (xfer || skip_hit);
   endsequence

   chk_phase_wrap: assert property (run && ph == `PH_LAST |=> ph == `PH_FETCH)
      else $error("phase did not wrap after four clocks");
   chk_reset_vec: assert property ($past(reset) |-> pc == `RESET_VEC && ph == `PH_FETCH)
      else $error("reset did not load vector");
   chk_one_cycle: assert property (s_plain |-> ##4 (commit || !run))
      else $error("plain instruction took extra cycle");
   chk_flush_gap: assert property (s_flush |-> ##4 !commit)
      else $error("no extra cycle after flow change");
   chk_jump_load: assert property (commit && is_jmp |=> !ir_valid && pc == $past(tgt))
      else $error("branch target not loaded");
   chk_call_save: assert property (commit && is_call |=> stk[sp - 2'h1] == $past(pc))
      else $error("call did not save next address");
   chk_ret_resume: assert property (commit && is_ret |=> pc == $past(ret_addr))
      else $error("return address wrong");
   chk_pcl_jump: assert property (commit && pcl_wr |=> !ir_valid && pc[7:0] == $past(mem_wdata))
      else $error("pc low write did not jump");
   chk_skip_not: assert property (commit && skip_op && !skip_hit |=> ir_valid)
      else $error("untaken skip flushed");
   chk_bit_only: assert property (mem_we && (op == `OP_BSET || op == `OP_BCLR)
      |-> ((mem_wdata ^ mem_rd) & ~mask) == 8'h00 && mem_wdata[bitidx] == (op == `OP_BSET))
      else $error("bit op touched other bits");
   chk_add_carry: assert property (commit && alu_op && fn == FN_ADD |=> flags.c == $past(chk_cout))
      else $error("add carry wrong");
   chk_logic_zero: assert property (commit && (op == `OP_ALU_A || op == `OP_ALU_X)
      && (fn == FN_AND || fn == FN_OR || fn == FN_XOR || fn == FN_CPL)
      |=> flags.z == (acc == 8'h00))
      else $error("logic zero flag wrong");
   chk_ld_imm: assert property (commit && op == `OP_LD_X |=> acc == $past(arg))
      else $error("immediate load wrong");
   chk_inc_one: assert property (commit && (op == `OP_ALU_A || op == `OP_ALU_X) && fn == FN_INC
      |=> acc == $past(opb) + 8'h01)
      else $error("increment not by one");
   chk_rot_carry: assert property (commit && (op == `OP_ALU_A || op == `OP_ALU_X) && fn == FN_RRC
      |=> flags.c == $past(opb[0]) && acc[7] == $past(flags.c))
      else $error("carry rotate wrong");
endmodule
`default_nettype wire

// [dv/prog_mem.sv]
// program memory model answering the core's instruction fetches
`timescale 1ns/10ps
`default_nettype none
module prog_mem
(
   input  wire core_pkg::pm_req_t pm_req,
   output logic [15:0]            pm_data
);
   import core_pkg::*;
   // instruction words, loaded by the bench
   logic [15:0] mem [0:1023];
   // word shown only during a fetch; otherwise inverted so a stale sample shows up
   always_comb
   begin
      if (pm_req.rd)
         pm_data = mem[pm_req.addr];
      else
         pm_data = ~mem[pm_req.addr];
   end
endmodule
`default_nettype wire

// [dv/mcu_instruction_execution_timing_tb.sv]
// self-checking bench for the core sequencer
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_execution_timing_tb;
   import core_pkg::*;
   logic        clk_sys;    // system clock
   logic        reset;      // synchronous reset
   logic [3:0]  bus_addr;   // register index
   logic [7:0]  bus_wdata;  // register write data
   logic        bus_we;     // write strobe
   logic        bus_re;     // read strobe
   logic [7:0]  bus_rdata;  // register read data
   pm_req_t     pm_req;     // fetch request
   logic [15:0] pm_data;    // fetched word
   int          failures;   // mismatches
   int          compares;   // comparisons made
   int          cyc;        // clock count
   int          last_t;     // clock of previous fetch
   int          nfetch;     // fetches since reset
   logic        re_q;       // read answer due this edge
   logic [7:0]  rq[$];      // expected read data
   logic [9:0]  fq[$];      // expected fetch addresses
   logic [15:0] prog_a [13];
   logic [15:0] w;
   logic [11:0] ref_v;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [2:0]  bi;
   logic [2:0]  bj;
   logic        k;

   core_seq DUT (.clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
                 .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .pm_req(pm_req), .pm_data(pm_data));
   prog_mem pmem (.pm_req(pm_req), .pm_data(pm_data));

   // 125 MHz clock
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;

   // compare one value and count it
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic conclude();
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // watcher: read answers and fetch stream against the noted expectations
   always @(posedge clk_sys)
   begin
      cyc++;
      re_q <= bus_re;
      if (re_q && rq.size() > 0)
         check({8'h00, bus_rdata}, {8'h00, rq.pop_front()}, "read data");
      else if (!reset && !re_q)
         check({8'h00, bus_rdata}, 16'h0000, "idle read data");
      if (reset)
      begin
         last_t = -1;
         nfetch = 0;
      end
      else if (pm_req.rd === 1'b1)
      begin
         if (last_t >= 0)
            check(16'(cyc - last_t), 16'h0004, "fetch spacing");
         last_t = cyc;
         nfetch++;
         if (fq.size() > 0)
            check({6'h00, pm_req.addr}, {6'h00, fq.pop_front()}, "fetch address");
      end
   end

   // one read strobe, expectation noted first
   task automatic bus_rd(input logic [3:0] ad, input logic [7:0] exp);
      rq.push_back(exp);
      bus_addr <= ad;
      bus_re   <= 1'b1;
      @(posedge clk_sys);
      bus_re <= 1'b0;
      @(posedge clk_sys);
   endtask

   // one write strobe
   task automatic bus_wr(input logic [3:0] ad, input logic [7:0] d);
      bus_addr  <= ad;
      bus_wdata <= d;
      bus_we    <= 1'b1;
      @(posedge clk_sys);
      bus_we <= 1'b0;
   endtask

   // hold reset two cycles and blank the program
   task automatic start();
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 1024; i++)
         pmem.mem[i] = 16'h0000;
   endtask

   // bounded wait for a number of fetches
   task automatic wait_fetch(input int n);
      int t;
      t = 0;
      reset <= 1'b0;
      @(posedge clk_sys);
      while (nfetch < n && t < 500)
      begin
         @(posedge clk_sys);
         t++;
      end
      if (nfetch < n)
      begin
         failures++;
         $display("[FAIL] %0t fetch stream stalled", $time);
         conclude();
      end
   endtask

   // reference result {res, z c ac ov} for the immediate alu class
   function automatic logic [11:0] alu_ref(input logic [3:0] fn, input logic [7:0] x, input logic [7:0] y,
                                           input logic [3:0] fi);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      logic [3:0] f;
      logic       ci;
      f  = fi;
      ci = (fn == 4'h1 || fn == 4'h3) ? fi[2] : 1'b0;
      s  = 9'h000;
      h  = 5'h00;
      r  = 8'h00;
      case (fn)
         4'h0, 4'h1:
         begin
            s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
            h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
         end
         4'h2, 4'h3:
         begin
            s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
            h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
         end
         4'h4: r = x & y;
         4'h5: r = x | y;
         4'h6: r = x ^ y;
         4'h7: r = ~y;
         4'h8: r = y + 8'h01;
         4'h9: r = y - 8'h01;
         4'hA: r = {y[0], y[7:1]};
         4'hB: r = {y[6:0], y[7]};
         4'hC: r = {fi[2], y[7:1]};
         4'hD: r = {y[6:0], fi[2]};
         4'hE: r = y;
         default: r = x;
      endcase
      if (fn < 4'h4)
      begin
         r = s[7:0];
         f = {r == 8'h00, s[8], h[4], (fn[1] ? (x[7] != y[7]) : (x[7] == y[7])) && (r[7] != x[7])};
      end
      else if (fn < 4'hA)
         f[3] = (r == 8'h00);
      else if (fn == 4'hC)
         f[2] = y[0];
      else if (fn == 4'hD)
         f[2] = y[7];
      return {r, f};
   endfunction

   // main sequence
   initial
   begin
      failures  = 0;
      compares  = 0;
      cyc       = 0;
      last_t    = -1;
      nfetch    = 0;
      re_q      = 1'b0;
      bus_addr  = 4'h0;
      bus_wdata = 8'h00;
      bus_we    = 1'b0;
      bus_re    = 1'b0;
      void'($urandom(71));
      // flow: pc low write, call, taken and untaken skips, return, self branch
      prog_a = '{16'h8004, 16'h7002, 16'h80EE, 16'h0000, 16'h7010, 16'h200C, 16'hC210,
                 16'h8077, 16'hB210, 16'h5004, 16'h100A, 16'h0000, 16'h0100};
      start();
      for (int i = 0; i < 13; i++)
         pmem.mem[i] = prog_a[i];
      fq = '{10'd0, 10'd1, 10'd2, 10'd4, 10'd5, 10'd6, 10'd12, 10'd13,
             10'd6, 10'd7, 10'd8, 10'd9, 10'd10, 10'd11, 10'd10, 10'd11};
      wait_fetch(16);
      bus_rd(4'h1, 8'h08);
      bus_rd(4'h3, 8'h00);
      bus_rd(4'hF, 8'h00);
      // single-bit set on every bit index, clear on a random bit index
      for (int i = 0; i < 8; i++)
      begin
         a  = 8'($urandom);
         bi = 3'(i);
         bj = 3'($urandom);
         start();
         pmem.mem[0] = {8'h80, a};
         pmem.mem[1] = 16'h7010;
         pmem.mem[2] = {5'h12, bi, 8'h10};
         pmem.mem[3] = {5'h14, bj, 8'h10};
         pmem.mem[4] = 16'h6010;
         pmem.mem[5] = 16'h1005;
         wait_fetch(9);
         bus_rd(4'h1, (a | (8'h01 << bi)) & ~(8'h01 << bj));
      end
      // every alu function with a random carry in
      for (int fn = 0; fn < 16; fn++)
      begin
         a = 8'($urandom);
         b = 8'($urandom);
         k = 1'($urandom);
         start();
         pmem.mem[0] = 16'h80FF;
         pmem.mem[1] = {8'h50, 7'h00, k};
         pmem.mem[2] = {8'h80, a};
         pmem.mem[3] = {4'h5, 4'(fn), b};
         pmem.mem[4] = 16'h1004;
         wait_fetch(8);
         ref_v = alu_ref(4'(fn), a, b, k ? 4'hE : 4'h0);
         bus_rd(4'h1, ref_v[11:4]);
         bus_rd(4'h3, {4'h0, ref_v[3:0]});
      end
      // table read from the top page, read-only accumulator, run control
      a = 8'($urandom);
      w = 16'($urandom);
      start();
      pmem.mem[0] = {8'h80, a};
      pmem.mem[1] = 16'h0300;
      pmem.mem[2] = 16'h1002;
      pmem.mem[{2'b11, a}] = w;
      wait_fetch(8);
      bus_wr(4'h1, ~w[7:0]);
      bus_rd(4'h1, w[7:0]);
      bus_rd(4'h4, w[15:8]);
      bus_rd(4'h0, 8'h01);
      bus_wr(4'h0, 8'h00);
      bus_rd(4'h0, 8'h00);
      repeat (4) @(posedge clk_sys);
      conclude();
   end
endmodule
`default_nettype wire
